// ==== core/ddr_burst2_sram_interface.sv ====
// double-rate sram port with two-word bursts, posted self-timed writes and echo strobes
// What this block does
// RULE_01 - A burst command is taken only on a true-phase edge, and then not again on the very next true-phase edge.
// RULE_02 - Only rising edges of the strobe pair sample the synchronous inputs, never a falling edge.
// RULE_03 - The two write words are registered on a true-phase rising edge and the comp-phase rising edge after it.
// RULE_04 - Read data leave output registers on the strobe pair's rising edges, as there is no separate output clock.
// RULE_05 - A one-bit burst counter starts from the low address pin and moves two words in sequence per access.
// RULE_06 - With loop_disable high a read returns its first word one and a half cycles after the command.
// RULE_07 - With loop_disable low a read returns its first word one cycle after the command.
// RULE_08 - Every synchronous input is held in a register on the strobe clock before it reaches the array.
// RULE_09 - Read and write data share one set of data pins, which the block drives only while read words are out.
// RULE_10 - The returned strobe pair changes on the same edges as the read data, so the controller can capture with it.
// RULE_11 - Writes finish in the array by an internal self-timed engine that needs no write pulse from outside.
// RULE_12 - The array is either one mebiword of 18 bits or 512 kibiwords of 36 bits, which fixes address and data width.
// RULE_13 - The controller marks a transaction by driving command_valid_n low with address and direction, two words each.
// RULE_14 - Whenever no read word is being returned the data drivers are switched off.
// RULE_15 - The controller puts the first write word at the true-phase edge and the second at the comp-phase edge after it.
// RULE_16 - The controller releases the data pins while read data are due, so the two ends never both drive.
module ddr_burst2_sram_interface
   import sram_pkg::*;
#(
   parameter bit WIDE = 1'b0,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   localparam int DATA_W = WIDE ? WIDE_WORD_W : NARROW_WORD_W,
   localparam int ADDR_W = WIDE ? WIDE_ADDR_W : NARROW_ADDR_W,
   localparam int BEAT_W = ADDR_W + DATA_W
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic input_strobe_clk,
   input wire logic loop_disable,
   input wire logic command_valid_n,
   input wire logic read_not_write,
   input wire logic [ADDR_W-2:0] address_pins,
   input wire logic burst_start_bit,
   input wire logic [DATA_W-1:0] data_pins_in,
   output logic [DATA_W-1:0] data_pins_out,
   output logic data_pins_oe,
   output logic [1:0] returned_strobe_pair,
   output logic write_buffer_ready,
   output logic write_overrun,
   output logic write_pending
);

   if (FIFO_DEPTH < 4 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_fifo
      $error("write buffer depth must be a power of two, at least 4");
   end

   if (LAT_EDGES_DIRECT < 2 || LAT_EDGES_LOOP + 1 > LINE_DEPTH + 1) begin : g_bad_lat
      $error("read latency does not fit the scheduling line");
   end

   // link domain: every rising edge of input_strobe_clk is a rising
   // edge of either the true or the comp strobe, alternating

   logic lrst_s1_q;
   logic lrst_s2_q;
   logic link_rst_n;

   // released on the link clock so no link flop leaves reset mid-edge
   always_ff @(posedge input_strobe_clk or negedge resetn) begin
      if (!resetn) begin
         lrst_s1_q <= 1'b0;
         lrst_s2_q <= 1'b0;
      end else begin
         lrst_s1_q <= 1'b1;
         lrst_s2_q <= lrst_s1_q;
      end
   end

   assign link_rst_n = lrst_s2_q;

   // board strap, not timed to the strobes; unreset so it is valid at the first command
   logic loop_s1_q;
   logic loop_s2_q;

   always_ff @(posedge input_strobe_clk) begin
      loop_s1_q <= loop_disable;
      loop_s2_q <= loop_s1_q;
   end

   logic phase_q;
   logic [1:0] hold_q;
   logic [1:0] hold_d;
   logic phase_true;
   logic cmd_take;
   logic cmd_read;
   logic cmd_write;
   logic [1:0] rd_slot;
   logic [ADDR_W-1:0] beat0_addr;
   logic [ADDR_W-1:0] beat1_addr;

   assign phase_true = (phase_q == PHASE_TRUE);
   assign cmd_take = !command_valid_n && phase_true && (hold_q == 2'h0); // [RULE_01] [RULE_13]
   assign cmd_read = cmd_take && read_not_write;
   assign cmd_write = cmd_take && !read_not_write;
   assign hold_d = cmd_take ? 2'(CMD_HOLD_EDGES) : (hold_q == 2'h0 ? 2'h0 : hold_q - 2'h1); // [RULE_01]

   // burst counter: second word flips the low bit, wrapping inside the pair
   assign beat0_addr = {address_pins, burst_start_bit}; // [RULE_05]
   assign beat1_addr = {address_pins, ~burst_start_bit}; // [RULE_05]

   // slot in the read line picks the latency; line head feeds the array
   assign rd_slot = loop_s2_q ? 2'(LAT_EDGES_LOOP - 2) : 2'(LAT_EDGES_DIRECT - 2); // [RULE_06] [RULE_07]

   always_ff @(posedge input_strobe_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         phase_q <= PHASE_TRUE;
         hold_q <= 2'h0;
      end else begin
         phase_q <= ~phase_q; // [RULE_02]
         hold_q <= hold_d;
      end
   end

   // scheduling lines: one entry per link edge, {valid, address}
   logic [ADDR_W:0] rd_line_q [LINE_DEPTH];
   logic [ADDR_W:0] wr_line_q [LINE_DEPTH];

   for (genvar i = 0; i < LINE_DEPTH; i++) begin : g_line
      logic [ADDR_W:0] rd_shift;
      logic [ADDR_W:0] wr_shift;
      logic [ADDR_W:0] rd_next;
      logic [ADDR_W:0] wr_next;

      if (i == LINE_DEPTH - 1) begin : g_tail
         assign rd_shift = '0;
         assign wr_shift = '0;
      end else begin : g_body
         assign rd_shift = rd_line_q[i+1];
         assign wr_shift = wr_line_q[i+1];
      end

      assign rd_next = (cmd_read && i == int'(rd_slot)) ? {1'b1, beat0_addr} :
                       (cmd_read && i == int'(rd_slot) + 1) ? {1'b1, beat1_addr} : rd_shift; // [RULE_05]
      assign wr_next = (cmd_write && i == WR_FIRST_EDGE - 1) ? {1'b1, beat0_addr} :
                       (cmd_write && i == WR_FIRST_EDGE) ? {1'b1, beat1_addr} : wr_shift; // [RULE_15]

      always_ff @(posedge input_strobe_clk or negedge link_rst_n) begin
         if (!link_rst_n) begin
            rd_line_q[i] <= '0;
            wr_line_q[i] <= '0;
         end else begin
            rd_line_q[i] <= rd_next;
            wr_line_q[i] <= wr_next;
         end
      end
   end

   // write capture and last-burst bypass

   logic wr_cap;
   logic [ADDR_W-1:0] wr_cap_addr;
   logic wbeat_valid_q;
   logic [BEAT_W-1:0] wbeat_data_q;
   logic overrun_q;

   assign wr_cap = wr_line_q[0][ADDR_W];
   assign wr_cap_addr = wr_line_q[0][ADDR_W-1:0];

   // the pins never wait, so a beat met by a full buffer is lost
   always_ff @(posedge input_strobe_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         wbeat_valid_q <= 1'b0;
         wbeat_data_q <= '0;
         overrun_q <= 1'b0;
      end else begin
         wbeat_valid_q <= wr_cap; // [RULE_03] [RULE_08]
         if (wr_cap) begin
            wbeat_data_q <= {wr_cap_addr, data_pins_in}; // [RULE_03] [RULE_08]
         end
         if (wbeat_valid_q && !write_buffer_ready) begin
            overrun_q <= 1'b1;
         end
      end
   end

   assign write_overrun = overrun_q;

   // posted writes reach the array late; the last burst is served from here
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [1:0] hit_bits;
   logic [DATA_W-1:0] byp_data_q [2];

   assign rd_en = rd_line_q[0][ADDR_W];
   assign rd_addr = rd_line_q[0][ADDR_W-1:0];

   for (genvar e = 0; e < BURST_LEN; e++) begin : g_bypass
      logic byp_valid_q;
      logic [ADDR_W-1:0] byp_addr_q;
      logic take;

      assign take = wr_cap && (wr_cap_addr[0] == 1'(e));
      assign hit_bits[e] = byp_valid_q && (byp_addr_q == rd_addr);

      always_ff @(posedge input_strobe_clk or negedge link_rst_n) begin
         if (!link_rst_n) begin
            byp_valid_q <= 1'b0;
            byp_addr_q <= '0;
            byp_data_q[e] <= '0;
         end else if (take) begin
            byp_valid_q <= 1'b1;
            byp_addr_q <= wr_cap_addr;
            byp_data_q[e] <= data_pins_in; // [RULE_03]
         end
      end
   end

   // read return: array read on one edge, launch on the next

   logic [DATA_W-1:0] arr_rd_data;
   logic launch_q;
   logic hit_q;
   logic [DATA_W-1:0] hit_data_q;
   logic [DATA_W-1:0] dout_q;
   logic oe_q;
   logic echo_true_q;
   logic echo_comp_q;
   logic [DATA_W-1:0] launch_data;

   assign launch_data = hit_q ? hit_data_q : arr_rd_data;

   always_ff @(posedge input_strobe_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         launch_q <= 1'b0;
         hit_q <= 1'b0;
         hit_data_q <= '0;
      end else begin
         launch_q <= rd_en;
         hit_q <= rd_en && hit_bits[rd_addr[0]];
         hit_data_q <= byp_data_q[rd_addr[0]];
      end
   end

   always_ff @(posedge input_strobe_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         dout_q <= '0;
         oe_q <= 1'b0;
         echo_true_q <= 1'b0;
         echo_comp_q <= 1'b0;
      end else begin
         if (launch_q) begin
            dout_q <= launch_data; // [RULE_04] [RULE_06] [RULE_07]
         end
         oe_q <= launch_q; // [RULE_09] [RULE_14] [RULE_16]
         echo_true_q <= phase_true; // [RULE_10]
         echo_comp_q <= !phase_true; // [RULE_10]
      end
   end

   assign data_pins_out = dout_q;
   assign data_pins_oe = oe_q; // [RULE_09] [RULE_14]
   assign returned_strobe_pair = {echo_comp_q, echo_true_q}; // [RULE_10]

   // write buffer between the strobe domain and the write engine

   beat_if #(.W(BEAT_W)) fill ();
   beat_if #(.W(BEAT_W)) drain ();

   assign fill.valid = wbeat_valid_q;
   assign fill.data = wbeat_data_q;
   assign write_buffer_ready = fill.ready;

   beat_fifo #(
      .W(BEAT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_buffer (
      .wr_clk(input_strobe_clk),
      .wr_rst_n(link_rst_n),
      .wr(fill),
      .rd_clk(clk_sys),
      .rd_rst_n(resetn),
      .rd(drain)
   );

   // self-timed write engine on the system clock

   write_engine_state_t we_state_q;
   write_engine_state_t we_state_d;
   logic [SETTLE_W-1:0] settle_q;
   logic [SETTLE_W-1:0] settle_d;
   logic [BEAT_W-1:0] we_word_q;
   logic we_pop;
   logic we_wr_en;

   assign drain.ready = (we_state_q == WE_IDLE);
   assign we_pop = drain.valid && drain.ready;
   assign we_wr_en = (we_state_q == WE_WRITE); // [RULE_11]

   always_comb begin
      we_state_d = we_state_q;
      settle_d = settle_q;
      case (we_state_q)
         WE_IDLE: begin
            if (drain.valid) begin
               we_state_d = WE_WRITE;
            end
         end
         WE_WRITE: begin
            we_state_d = WE_SETTLE;
            settle_d = '0;
         end
         WE_SETTLE: begin
            // recovery time of the cell before the next word may land
            if (settle_q == SETTLE_W'(WRITE_SETTLE_CYC - 1)) begin
               we_state_d = WE_IDLE;
            end else begin
               settle_d = settle_q + SETTLE_W'(1);
            end
         end
         default: begin
            we_state_d = WE_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         we_state_q <= WE_IDLE;
         settle_q <= '0;
         we_word_q <= '0;
      end else begin
         we_state_q <= we_state_d; // [RULE_11]
         settle_q <= settle_d;
         if (we_pop) begin
            we_word_q <= drain.data;
         end
      end
   end

   assign write_pending = drain.valid || (we_state_q != WE_IDLE);

   // older bursts still queued are not forwarded: a read of them sees old data
   sram_array #(
      .AW(ADDR_W),
      .DW(DATA_W)
   ) u_array ( // [RULE_12]
      .wr_clk(clk_sys),
      .wr_en(we_wr_en),
      .wr_addr(we_word_q[BEAT_W-1:DATA_W]),
      .wr_data(we_word_q[DATA_W-1:0]),
      .rd_clk(input_strobe_clk),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data_q(arr_rd_data)
   );

endmodule : ddr_burst2_sram_interface

// ==== shared/sram_pkg.sv ====
// shared constants and types for the two-word burst double-rate sram port
package sram_pkg;
   localparam int NARROW_WORD_W = 18;
   localparam int WIDE_WORD_W = 36;
   localparam int NARROW_ADDR_W = 20;
   localparam int WIDE_ADDR_W = 19;
   localparam int BURST_LEN = 2;
   // link edges: every rising edge of the strobe pair counts, two per cycle
   localparam int LAT_EDGES_LOOP = 3;
   localparam int LAT_EDGES_DIRECT = 2;
   localparam int WR_FIRST_EDGE = 2;
   localparam int CMD_HOLD_EDGES = 3;
   localparam int LINE_DEPTH = 3;
   localparam int FIFO_DEPTH_DEF = 16;
   localparam logic PHASE_TRUE = 1'h0;
   localparam int CLK_SYS_NS = 50;
   localparam int WRITE_SETTLE_NS = 60;
   localparam int WRITE_SETTLE_CYC = (WRITE_SETTLE_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
   localparam int SETTLE_W = 4;
   typedef enum logic [1:0] {
      WE_IDLE,
      WE_WRITE,
      WE_SETTLE
   } write_engine_state_t;
endpackage : sram_pkg

// ==== shared/beat_if.sv ====
// valid/ready carrier for write beats between port logic and buffer
interface beat_if #(
   parameter int W = 8
);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface : beat_if

// ==== core/sram_array.sv ====
// storage array: write port on one clock, registered read port on another
module sram_array #(
   parameter int AW = 20,
   parameter int DW = 18
) (
   input wire logic wr_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic rd_clk,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data_q
);
   logic [DW-1:0] cell_q [2**AW];

   always_ff @(posedge wr_clk) begin
      if (wr_en) begin
         cell_q[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge rd_clk) begin
      if (rd_en) begin
         rd_data_q <= cell_q[rd_addr];
      end
   end
endmodule : sram_array

// ==== core/beat_fifo.sv ====
// dual-clock beat buffer with gray-coded pointers
module beat_fifo
   import sram_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic wr_clk,
   input wire logic wr_rst_n,
   beat_if.sink wr,
   input wire logic rd_clk,
   input wire logic rd_rst_n,
   beat_if.source rd
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("beat_fifo depth must be a power of two, at least 4");
   end

   logic [W-1:0] slot_q [DEPTH];
   logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
   logic [AW:0] rgray_s1_q, rgray_s2_q, wgray_s1_q, wgray_s2_q;

   wire push = wr.valid && wr.ready;
   wire pop = rd.valid && rd.ready;
   wire [AW:0] wbin_n = wbin_q + {{AW{1'b0}}, push};
   wire [AW:0] rbin_n = rbin_q + {{AW{1'b0}}, pop};
   wire [AW:0] full_gray = {~rgray_s2_q[AW:AW-1], rgray_s2_q[AW-2:0]};

   assign wr.ready = (wgray_q != full_gray);
   assign rd.valid = (rgray_q != wgray_s2_q);
   assign rd.data = slot_q[rbin_q[AW-1:0]];

   always_ff @(posedge wr_clk) begin
      if (push) begin
         slot_q[wbin_q[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge wr_clk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         wbin_q <= '0;
         wgray_q <= '0;
         rgray_s1_q <= '0;
         rgray_s2_q <= '0;
      end else begin
         wbin_q <= wbin_n;
         wgray_q <= (wbin_n >> 1) ^ wbin_n;
         rgray_s1_q <= rgray_q;
         rgray_s2_q <= rgray_s1_q;
      end
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         rbin_q <= '0;
         rgray_q <= '0;
         wgray_s1_q <= '0;
         wgray_s2_q <= '0;
      end else begin
         rbin_q <= rbin_n;
         rgray_q <= (rbin_n >> 1) ^ rbin_n;
         wgray_s1_q <= wgray_q;
         wgray_s2_q <= wgray_s1_q;
      end
   end
endmodule : beat_fifo

// ==== tb/sram_port_checker_assertions.sv ====
// concurrent checks on the pins of the burst sram port
module sram_port_checker
   import sram_pkg::*;
#(
   parameter bit WIDE = 1'b0,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   localparam int DW_L = WIDE ? WIDE_WORD_W : NARROW_WORD_W,
   localparam int AW_L = WIDE ? WIDE_ADDR_W : NARROW_ADDR_W
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic input_strobe_clk,
   input wire logic loop_disable,
   input wire logic command_valid_n,
   input wire logic read_not_write,
   input wire logic [AW_L-2:0] address_pins,
   input wire logic burst_start_bit,
   input wire logic [DW_L-1:0] data_pins_in,
   input wire logic [DW_L-1:0] data_pins_out,
   input wire logic data_pins_oe,
   input wire logic [1:0] returned_strobe_pair,
   input wire logic write_buffer_ready,
   input wire logic write_overrun,
   input wire logic write_pending
);
   timeunit 1ns;
   timeprecision 100ps;
   // echo shows the phase of the previous edge, so 2'b10 means this edge is true
   logic [1:0] took_q;
   wire true_edge = (returned_strobe_pair == 2'h2);
   wire take = !command_valid_n && true_edge && !took_q[1];
   wire rd_take = take && read_not_write;
   wire wr_take = take && !read_not_write;
   always_ff @(posedge input_strobe_clk or negedge resetn) begin
      if (!resetn) took_q <= 2'h0;
      else took_q <= {took_q[0], take};
   end
   sequence s_oe_burst;
      !data_pins_oe ##1 data_pins_oe [*2] ##1 !data_pins_oe;
   endsequence
   sequence s_rd_take;
      rd_take;
   endsequence
   AST_RD_LAT_LOOP: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      s_rd_take ##0 loop_disable |-> ##3 s_oe_burst) else $error("read burst late or wrong length, loop on");
   AST_RD_LAT_DIRECT: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      s_rd_take ##0 !loop_disable |-> ##2 s_oe_burst) else $error("read burst late or wrong length, loop off");
   AST_OE_CAUSE: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      $rose(data_pins_oe) |-> (loop_disable ? $past(rd_take, 4) : $past(rd_take, 3)))
      else $error("drivers on without a taken read");
   AST_OE_PHASE: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      $rose(data_pins_oe) |-> returned_strobe_pair == (loop_disable ? 2'h2 : 2'h1))
      else $error("first read word on wrong strobe phase");
   AST_ECHO_ALT: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      returned_strobe_pair inside {2'h1, 2'h2} |=> returned_strobe_pair == ~$past(returned_strobe_pair))
      else $error("echo strobes do not alternate");
   AST_ECHO_EXCL: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      returned_strobe_pair != 2'h3) else $error("both echo strobes high");
   AST_WR_NO_DRIVE: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      wr_take |-> ##2 !data_pins_oe [*5]) else $error("drivers on during a write burst");
   AST_WR_PENDING: assert property (@(posedge input_strobe_clk) disable iff (!resetn)
      wr_take |-> ##[4:16] write_pending) else $error("write never reached the write engine");
   AST_OVERRUN_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      write_overrun |=> write_overrun) else $error("overrun flag dropped without reset");
   COV_FULL: cover property (@(posedge input_strobe_clk) disable iff (!resetn) !write_buffer_ready);
endmodule : sram_port_checker

// ==== tb/host_ctrl_model.sv ====
// memory controller model: commands, write words and the shared data wire
module host_ctrl_model
   import sram_pkg::*;
(
   input wire logic input_strobe_clk,
   input wire logic resetn,
   input wire logic [NARROW_WORD_W-1:0] data_pins_out,
   input wire logic data_pins_oe,
   output logic command_valid_n,
   output logic read_not_write,
   output logic [NARROW_ADDR_W-2:0] address_pins,
   output logic burst_start_bit,
   output logic [NARROW_WORD_W-1:0] data_pins_in
);
   timeunit 1ns;
   timeprecision 100ps;
   int edge_q;
   logic host_oe_q = 1'b0;
   logic [NARROW_WORD_W-1:0] host_d_q = 18'h0_0000;
   logic [NARROW_WORD_W-1:0] last_q = 18'h0_0000;
   // nobody driving: show the inverse of the last level, never a stale copy
   assign data_pins_in = data_pins_oe ? data_pins_out : (host_oe_q ? host_d_q : ~last_q);
   always @(posedge input_strobe_clk) last_q <= data_pins_in;
   always_ff @(posedge input_strobe_clk or negedge resetn) begin
      if (!resetn) edge_q <= 0;
      else edge_q <= edge_q + 1;
   end
   initial begin
      command_valid_n = 1'b1;
      read_not_write = 1'b0;
      address_pins = 19'h0_0000;
      burst_start_bit = 1'b0;
   end
   // edge_q holds the previous edge count here; odd means the next edge is true phase
   task automatic issue(input logic rnw, input logic [18:0] a, input logic b, input int hold, input int skew);
      do @(posedge input_strobe_clk); while (edge_q % 2 == 0);
      repeat (skew) @(posedge input_strobe_clk);
      command_valid_n <= 1'b0;
      read_not_write <= rnw;
      address_pins <= a;
      burst_start_bit <= b;
      repeat (hold) @(posedge input_strobe_clk);
      command_valid_n <= 1'b1;
      address_pins <= ~a;
      burst_start_bit <= ~b;
   endtask : issue
   task automatic write_burst(input logic [18:0] a, input logic b, input logic [17:0] w0, input logic [17:0] w1);
      issue(1'b0, a, b, 1, 0);
      @(posedge input_strobe_clk);
      host_oe_q <= 1'b1;
      host_d_q <= w0;
      @(posedge input_strobe_clk);
      host_d_q <= w1;
      @(posedge input_strobe_clk);
      host_oe_q <= 1'b0;
      host_d_q <= ~w1;
   endtask : write_burst
   task automatic read_burst(input logic [18:0] a, input logic b, input int lat, input int hold, input int skew,
                             output logic [17:0] d0, output logic [17:0] d1, output logic [4:0] pat);
      int i;
      issue(1'b1, a, b, hold, skew);
      repeat (lat - hold + 1) @(posedge input_strobe_clk);
      for (i = 0; i < 5; i++) begin
         #1;
         if (i == 0) d0 = data_pins_out;
         if (i == 1) d1 = data_pins_out;
         pat[i] = data_pins_oe;
         @(posedge input_strobe_clk);
      end
   endtask : read_burst
endmodule : host_ctrl_model

// ==== tb/ddr_burst2_sram_interface_test.sv ====
// self-checking bench for the burst sram port
module ddr_burst2_sram_interface_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic input_strobe_clk = 1'b0;
   logic resetn = 1'b0;
   logic loop_disable = 1'b1;
   wire logic command_valid_n, read_not_write, burst_start_bit, data_pins_oe;
   wire logic write_buffer_ready, write_overrun, write_pending;
   wire logic [18:0] address_pins;
   wire logic [17:0] data_pins_in, data_pins_out;
   wire logic [1:0] returned_strobe_pair;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   logic saw_full = 1'b0;
   always #25 clk_sys = ~clk_sys;
   always #24 input_strobe_clk = ~input_strobe_clk;
   always @(posedge input_strobe_clk) if (write_buffer_ready === 1'b0) saw_full <= 1'b1;
   ddr_burst2_sram_interface u_dut (.clk_sys(clk_sys), .resetn(resetn), .input_strobe_clk(input_strobe_clk),
      .loop_disable(loop_disable), .command_valid_n(command_valid_n), .read_not_write(read_not_write),
      .address_pins(address_pins), .burst_start_bit(burst_start_bit), .data_pins_in(data_pins_in),
      .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .returned_strobe_pair(returned_strobe_pair),
      .write_buffer_ready(write_buffer_ready), .write_overrun(write_overrun), .write_pending(write_pending));
   host_ctrl_model u_host (.input_strobe_clk(input_strobe_clk), .resetn(resetn), .data_pins_out(data_pins_out),
      .data_pins_oe(data_pins_oe), .command_valid_n(command_valid_n), .read_not_write(read_not_write),
      .address_pins(address_pins), .burst_start_bit(burst_start_bit), .data_pins_in(data_pins_in));
   task automatic report_and_stop();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // hang guard: the whole sequence needs well under 2000 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic cmp_word(input string nm, input logic [17:0] e, input logic [17:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp_bit
   task automatic chk_read(input logic [18:0] a, input logic b, input int lat, input int hold, input int skew,
                           input logic [17:0] e0, input logic [17:0] e1, input logic [4:0] epat);
      logic [17:0] r0, r1;
      logic [4:0] pat;
      u_host.read_burst(a, b, lat, hold, skew, r0, r1, pat);
      cmp_word("oe pattern", {13'h0, epat}, {13'h0, pat});
      if (epat != 5'h0) begin
         cmp_word("word0", e0, r0);
         cmp_word("word1", e1, r1);
      end
   endtask : chk_read
   task automatic wait_idle();
      int n;
      n = 0;
      while (write_pending !== 1'b0 && n < 1000) begin
         @(posedge clk_sys);
         n++;
      end
      cmp_bit("write_pending", 1'b0, write_pending);
   endtask : wait_idle
   task automatic t_write_read();
      u_host.write_burst(19'h0_1234, 1'b0, 18'h2_5a5a, 18'h1_c3c3);
      u_host.write_burst(19'h0_4321, 1'b1, 18'h0_0f0f, 18'h3_f00f);
      wait_idle();
      chk_read(19'h0_1234, 1'b0, 3, 1, 0, 18'h2_5a5a, 18'h1_c3c3, 5'h03);
      chk_read(19'h0_1234, 1'b1, 3, 1, 0, 18'h1_c3c3, 18'h2_5a5a, 5'h03);
      chk_read(19'h0_4321, 1'b0, 3, 1, 0, 18'h3_f00f, 18'h0_0f0f, 5'h03);
   endtask : t_write_read
   task automatic t_direct();
      @(posedge input_strobe_clk);
      loop_disable <= 1'b0;
      repeat (4) @(posedge input_strobe_clk);
      chk_read(19'h0_4321, 1'b1, 2, 1, 0, 18'h0_0f0f, 18'h3_f00f, 5'h03);
      loop_disable <= 1'b1;
      repeat (4) @(posedge input_strobe_clk);
   endtask : t_direct
   task automatic t_refused();
      chk_read(19'h0_1234, 1'b0, 3, 1, 1, 18'h0_0000, 18'h0_0000, 5'h00);
      chk_read(19'h0_1234, 1'b0, 3, 3, 0, 18'h2_5a5a, 18'h1_c3c3, 5'h03);
   endtask : t_refused
   task automatic t_fill();
      int i;
      // link side outruns the write engine, so the buffer must refuse beats
      for (i = 0; i < 40; i++) u_host.write_burst(19'h1_0000 + i, 1'b0, 18'h0_0100 + i, 18'h0_0200 + i);
      cmp_bit("buffer refused", 1'b1, saw_full);
      cmp_bit("write_overrun", 1'b1, write_overrun);
      wait_idle();
      chk_read(19'h0_0000 + 19'h1_0000, 1'b0, 3, 1, 0, 18'h0_0100, 18'h0_0200, 5'h03);
   endtask : t_fill
   task automatic t_reset();
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      cmp_bit("oe in reset", 1'b0, data_pins_oe);
      cmp_word("echo in reset", 18'h0_0000, {16'h0, returned_strobe_pair});
      cmp_bit("ready in reset", 1'b1, write_buffer_ready);
      cmp_bit("overrun in reset", 1'b0, write_overrun);
      cmp_bit("pending in reset", 1'b0, write_pending);
      @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk_read(19'h0_4321, 1'b0, 3, 1, 0, 18'h3_f00f, 18'h0_0f0f, 5'h03);
   endtask : t_reset
   initial begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_write_read();
      t_direct();
      t_refused();
      t_fill();
      t_reset();
      report_and_stop();
   end
endmodule : ddr_burst2_sram_interface_test
bind ddr_burst2_sram_interface sram_port_checker #(.WIDE(WIDE), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .input_strobe_clk(input_strobe_clk), .loop_disable(loop_disable),
   .command_valid_n(command_valid_n), .read_not_write(read_not_write), .address_pins(address_pins),
   .burst_start_bit(burst_start_bit), .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
   .data_pins_oe(data_pins_oe), .returned_strobe_pair(returned_strobe_pair),
   .write_buffer_ready(write_buffer_ready), .write_overrun(write_overrun), .write_pending(write_pending));
